// [dcss_delay.sv]
// start delay timer for terminal run commands
`default_nettype none
module dcss_delay
  import dcss_pkg::*;
#(
  parameter int TICK_CYC = DLY_TICK_CYC
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic req_i, // terminal run request level
  input wire logic [DLY_W-1:0] units_i, // delay in 10 ms units
  output logic done_o // delay elapsed, holds while req_i
);
  localparam int PW = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
  logic [PW-1:0] pre_ff;
  logic [DLY_W-1:0] cnt_ff;

  // dropping the request restarts the delay from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i) begin
      pre_ff <= '0;
      cnt_ff <= '0;
      done_o <= 1'b0;
    end else if (!done_o) begin
      if (cnt_ff >= units_i) begin
        done_o <= 1'b1;
      end else if (pre_ff == PW'(TICK_CYC - 1)) begin
        pre_ff <= '0;
        cnt_ff <= cnt_ff + 1'b1;
      end else begin
        pre_ff <= pre_ff + 1'b1;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_no_early_done;
    req_i && !done_o && (cnt_ff < units_i) |=> !done_o;
  endproperty
  a_no_early_done: assert property (p_no_early_done)
    else $error("start delay finished early");
endmodule
`default_nettype wire

// [dcss_far_model.sv]
// far side model: operator panel keys and terminal contacts
`default_nettype none
module dcss_far_model (
  input wire logic clk_i, // core clock
  output logic [2:0] key_o, // stop, rev, fwd key contacts
  output logic [10:0] term_o // terminal contacts
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    key_o = 3'h0;
    term_o = 11'h000;
  end
  // ==========================================================
  // operator actions
  // a press lasts several cycles, like a hand on a key
  task automatic press(input int k);
    @(posedge clk_i);
    key_o[k] <= 1'b1;
    repeat (4) @(posedge clk_i);
    key_o[k] <= 1'b0;
  endtask
  task automatic contact(input int t, input logic v);
    @(posedge clk_i);
    term_o[t] <= v;
  endtask
endmodule
`default_nettype wire

// [dcss_pkg.sv]
// constants shared by the drive command source selection block
`default_nettype none
package dcss_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 25_000_000;
  localparam int DLY_UNIT_MS = 10;
  localparam int DLY_TICK_CYC = CLK_HZ / 1000 * DLY_UNIT_MS;
  localparam int DLY_W = 14;
  localparam logic [13:0] DLY_MAX = 14'h2710;
  localparam logic [13:0] DLY_RST = 14'h0064;
  // ==========================================================
  // terminals and roles
  localparam int N_TERM = 11;
  localparam int ROLE_W = 6;
  localparam logic [5:0] ROLE_MAX = 6'h33;
  localparam logic [5:0] ROLE_FWD = 6'h01;
  localparam logic [5:0] ROLE_REV = 6'h02;
  localparam logic [5:0] ROLE_RST = 6'h00;
  // ==========================================================
  // command source codes
  localparam logic [2:0] SRC_KEYPAD = 3'h0;
  localparam logic [2:0] SRC_FWD_REV = 3'h1;
  localparam logic [2:0] SRC_RUN_DIR = 3'h2;
  localparam logic [2:0] SRC_SERIAL = 3'h3;
  localparam logic [2:0] SRC_FBUS = 3'h4;
  localparam logic [2:0] SRC_PLC = 3'h5;
  localparam logic [2:0] SRC_RST = 3'h0;
  // ==========================================================
  // serial port settings
  localparam logic [7:0] STN_MIN = 8'h01;
  localparam logic [7:0] STN_MAX = 8'hFA;
  localparam logic [7:0] STN_RST = 8'h01;
  localparam logic [3:0] PROTO_RST = 4'h0;
  localparam logic [3:0] RATE_MAX = 4'h5;
  localparam logic [3:0] RATE_RST = 4'h3;
  localparam logic [3:0] FRAME_RST = 4'h0;
  localparam int SER_STN_LSB = 0;
  localparam int SER_PROTO_LSB = 8;
  localparam int SER_RATE_LSB = 12;
  localparam int SER_FRAME_LSB = 16;
  // ==========================================================
  // register map and status fields
  localparam logic [7:0] OFS_SRC = 8'h00;
  localparam logic [7:0] OFS_DLY = 8'h04;
  localparam logic [7:0] OFS_SER = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_ROLE = 8'h10;
  localparam int STAT_FWD = 0;
  localparam int STAT_REV = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_SRC_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [dcss_sync.sv]
// two-stage synchroniser for pin inputs
`default_nettype none
module dcss_sync #(
  parameter int W = 1
) (
  input wire logic clk_i, // core clock
  input wire logic rst_i, // synchronous reset
  input wire logic [W-1:0] d_i, // asynchronous level
  output logic [W-1:0] q_o // synchronised level
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      q_o <= '0;
    end else begin
      meta_ff <= d_i;
      q_o <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// [dcss_tb_top.sv]
// self-checking bench for command source selection
`default_nettype none
module dcss_tb_top
  import dcss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, run_fwd, run_rev, dly_busy;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] stn;
  logic [3:0] proto, rate, frame;
  logic [2:0] key;
  logic [10:0] term;
  // plc rev, plc run, fbus rev, fbus run, serial rev, serial run
  logic [5:0] eng = 6'h00;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #20 clk = ~clk;
  // ==========================================================
  // design and far side
  dcss_top #(.TICK_CYC(4)) u_dcss_top (
    .CORE_CLK_I(clk), .SYS_RST_I(rst), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid),
    .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
    .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready), .RDATA_O(rdata),
    .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready), .KEY_FWD_I(key[0]),
    .KEY_REV_I(key[1]), .KEY_STOP_I(key[2]), .MULTI_FUNCTION_INPUT_I(term),
    .SER_RUN_I(eng[0]), .SER_REV_I(eng[1]), .FBUS_RUN_I(eng[2]), .FBUS_REV_I(eng[3]),
    .PLC_RUN_I(eng[4]), .PLC_REV_I(eng[5]), .RUN_FWD_O(run_fwd), .RUN_REV_O(run_rev),
    .DLY_BUSY_O(dly_busy), .SERIAL_STATION_NUMBER_O(stn), .SERIAL_PROTOCOL_SELECT_O(proto),
    .SERIAL_BIT_RATE_O(rate), .SERIAL_FRAME_FORMAT_O(frame));
  dcss_far_model u_dcss_far_model (.clk_i(clk), .key_o(key), .term_o(term));
  // ==========================================================
  // access and compare tasks
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    check(nm, rd, e);
    check("rresp", {30'h0, rresp}, {30'h0, er});
  endtask
  // sample a little after the edge so the design's updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic run_is(input logic f, input logic r);
    check("run", {30'h0, run_fwd, run_rev}, {30'h0, f, r});
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk("src", OFS_SRC, 32'h0, RESP_OKAY);
    rd_chk("dly", OFS_DLY, 32'h64, RESP_OKAY);
    rd_chk("ser", OFS_SER, 32'h3001, RESP_OKAY);
    check("rate", {28'h0, rate}, 32'h3);
    check("proto", {28'h0, proto}, 32'h0);
    rd_chk("role0", OFS_ROLE, 32'h0, RESP_OKAY);
    rd_chk("gap", 8'h40, 32'h0, RESP_SLVERR);
    $display("test reset done");
    wr(OFS_SRC, 32'h6);
    rd_chk("src", OFS_SRC, 32'h0, RESP_OKAY);
    wr(8'h44, 32'h1);
    check("bresp", {30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(OFS_SER, 32'h16005);
    check("bresp_ok", {30'h0, resp}, {30'h0, RESP_OKAY});
    rd_chk("ser", OFS_SER, 32'h13005, RESP_OKAY);
    check("stn", {24'h0, stn}, 32'h5);
    check("frame", {28'h0, frame}, 32'h1);
    wr(OFS_ROLE + 8'h08, 32'h34);
    rd_chk("role2", OFS_ROLE + 8'h08, 32'h0, RESP_OKAY);
    $display("test registers done");
    u_dcss_far_model.press(0);
    wait_cyc(8);
    run_is(1'b1, 1'b0);
    u_dcss_far_model.press(2);
    wait_cyc(8);
    run_is(1'b0, 1'b0);
    u_dcss_far_model.press(1);
    wait_cyc(8);
    run_is(1'b0, 1'b1);
    rd_chk("stat", OFS_STAT, 32'h2, RESP_OKAY);
    $display("test keypad done");
    wr(OFS_ROLE, {26'h0, ROLE_FWD});
    wr(OFS_ROLE + 8'h04, {26'h0, ROLE_REV});
    wr(OFS_DLY, 32'h2);
    wr(OFS_SRC, 32'h1);
    wait_cyc(8);
    run_is(1'b0, 1'b0);
    u_dcss_far_model.contact(0, 1'b1);
    wait_cyc(5);
    check("busy", {31'h0, dly_busy}, 32'h1);
    run_is(1'b0, 1'b0);
    wait_cyc(20);
    run_is(1'b1, 1'b0);
    u_dcss_far_model.contact(1, 1'b1);
    wait_cyc(8);
    run_is(1'b0, 1'b0);
    u_dcss_far_model.contact(0, 1'b0);
    wait_cyc(30);
    run_is(1'b0, 1'b1);
    u_dcss_far_model.contact(1, 1'b0);
    wait_cyc(8);
    run_is(1'b0, 1'b0);
    $display("test scheme one done");
    wr(OFS_SRC, 32'h2);
    u_dcss_far_model.contact(0, 1'b1);
    wait_cyc(30);
    run_is(1'b1, 1'b0);
    u_dcss_far_model.contact(1, 1'b1);
    wait_cyc(8);
    run_is(1'b0, 1'b1);
    u_dcss_far_model.contact(0, 1'b0);
    wait_cyc(8);
    run_is(1'b0, 1'b0);
    $display("test scheme two done");
    // terminals stay asserted so a leak from them would show
    u_dcss_far_model.contact(0, 1'b1);
    for (int s = 3; s <= 5; s++) begin
      wr(OFS_SRC, 32'(s));
      @(posedge clk);
      eng <= 6'h3F ^ (6'h02 << (2 * (s - 3)));
      wait_cyc(4);
      run_is(1'b1, 1'b0);
      // selected source now asks for reverse as well
      @(posedge clk);
      eng <= 6'h3F;
      wait_cyc(4);
      run_is(1'b0, 1'b1);
      @(posedge clk);
      eng <= 6'h3F ^ (6'h01 << (2 * (s - 3)));
      wait_cyc(4);
      run_is(1'b0, 1'b0);
    end
    $display("test remote sources done");
    wrap_up();
  end
endmodule
`default_nettype wire

// [dcss_top.sv]
// command source selection with AXI4-Lite configuration registers
//
// Added by the designer: register access over AXI4-Lite and the address map.
`default_nettype none
module dcss_top
  import dcss_pkg::*;
#(
  parameter int AW = 8,
  parameter int TICK_CYC = DLY_TICK_CYC
) (
  input wire logic CORE_CLK_I, // 25 MHz core clock
  input wire logic SYS_RST_I, // synchronous reset, high
  input wire logic [AW-1:0] AWADDR_I, // write address
  input wire logic AWVALID_I, // write address valid
  output logic AWREADY_O, // write address ready
  input wire logic [31:0] WDATA_I, // write data
  input wire logic [3:0] WSTRB_I, // write byte enables
  input wire logic WVALID_I, // write data valid
  output logic WREADY_O, // write data ready
  output logic [1:0] BRESP_O, // write response
  output logic BVALID_O, // write response valid
  input wire logic BREADY_I, // write response ready
  input wire logic [AW-1:0] ARADDR_I, // read address
  input wire logic ARVALID_I, // read address valid
  output logic ARREADY_O, // read address ready
  output logic [31:0] RDATA_O, // read data
  output logic [1:0] RRESP_O, // read response
  output logic RVALID_O, // read data valid
  input wire logic RREADY_I, // read data ready
  input wire logic KEY_FWD_I, // panel forward key pin
  input wire logic KEY_REV_I, // panel reverse key pin
  input wire logic KEY_STOP_I, // panel stop/reset key pin
  input wire logic [N_TERM-1:0] MULTI_FUNCTION_INPUT_I, // terminal pins
  input wire logic SER_RUN_I, // serial engine run request
  input wire logic SER_REV_I, // serial engine reverse request
  input wire logic FBUS_RUN_I, // field bus run request
  input wire logic FBUS_REV_I, // field bus reverse request
  input wire logic PLC_RUN_I, // built-in controller run request
  input wire logic PLC_REV_I, // built-in controller reverse request
  output logic RUN_FWD_O, // run forward request
  output logic RUN_REV_O, // run reverse request
  output logic DLY_BUSY_O, // start delay in progress
  output logic [7:0] SERIAL_STATION_NUMBER_O, // station address
  output logic [3:0] SERIAL_PROTOCOL_SELECT_O, // protocol code
  output logic [3:0] SERIAL_BIT_RATE_O, // bit rate code
  output logic [3:0] SERIAL_FRAME_FORMAT_O // frame format code
);
  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // any synchronised terminal carrying the role code counts
  function automatic logic role_hit(input logic [N_TERM-1:0][ROLE_W-1:0] roles,
                                    input logic [N_TERM-1:0] pins,
                                    input logic [ROLE_W-1:0] code);
    logic h;
    h = 1'b0;
    for (int i = 0; i < N_TERM; i++) begin
      if (pins[i] && roles[i] == code) begin
        h = 1'b1;
      end
    end
    return h;
  endfunction

  // ==========================================================
  // registers and internal state
  logic [2:0] command_source_select_ff;
  logic [DLY_W-1:0] run_delay_ff;
  logic [N_TERM-1:0][ROLE_W-1:0] terminal_role_assign_ff;
  logic [AW-1:0] wr_addr_ff;
  logic [31:0] wr_data_ff;
  logic [3:0] wr_strb_ff;
  logic [2:0] key_s;
  logic [2:0] key_prev_ff;
  logic [N_TERM-1:0] term_s;
  logic kp_fwd_ff;
  logic kp_rev_ff;
  logic do_wr;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [31:0] wv;
  logic fwd_in;
  logic rev_in;
  logic term_req;
  logic dly_done;
  logic nxt_fwd;
  logic nxt_rev;

  // ==========================================================
  // pin synchronisers and start delay
  dcss_sync #(.W(3 + N_TERM)) u_sync (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .d_i({KEY_STOP_I, KEY_REV_I, KEY_FWD_I, MULTI_FUNCTION_INPUT_I}),
    .q_o({key_s, term_s})
  );

  dcss_delay #(.TICK_CYC(TICK_CYC)) u_delay (
    .clk_i(CORE_CLK_I),
    .rst_i(SYS_RST_I),
    .req_i(term_req),
    .units_i(run_delay_ff),
    .done_o(dly_done)
  );

  // ==========================================================
  // AXI4-Lite write channel
  // address and data are taken in either order; the write lands once both are held
  assign do_wr = !AWREADY_O && !WREADY_O && !BVALID_O;
  assign wv = merge(32'h0000_0000, wr_data_ff, 4'hF);

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      AWREADY_O <= 1'b1;
      WREADY_O <= 1'b1;
      BVALID_O <= 1'b0;
      BRESP_O <= RESP_OKAY;
      wr_addr_ff <= '0;
      wr_data_ff <= 32'h0000_0000;
      wr_strb_ff <= 4'h0;
    end else begin
      if (AWREADY_O && AWVALID_I) begin
        AWREADY_O <= 1'b0;
        wr_addr_ff <= AWADDR_I;
      end
      if (WREADY_O && WVALID_I) begin
        WREADY_O <= 1'b0;
        wr_data_ff <= WDATA_I;
        wr_strb_ff <= WSTRB_I;
      end
      if (do_wr) begin
        BVALID_O <= 1'b1;
        BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID_O && BREADY_I) begin
        BVALID_O <= 1'b0;
        AWREADY_O <= 1'b1;
        WREADY_O <= 1'b1;
      end
    end
  end

  always_comb begin
    wr_hit = (wr_addr_ff == AW'(OFS_SRC)) || (wr_addr_ff == AW'(OFS_DLY)) ||
             (wr_addr_ff == AW'(OFS_SER)) || (wr_addr_ff == AW'(OFS_STAT));
    for (int i = 0; i < N_TERM; i++) begin
      if (wr_addr_ff == AW'(OFS_ROLE + 4 * i)) begin
        wr_hit = 1'b1;
      end
    end
  end

  // ==========================================================
  // configuration registers; out-of-range values are refused and the old value kept
  always_ff @(posedge CORE_CLK_I) begin
    logic [31:0] m;
    m = merge({29'h0, command_source_select_ff}, wv, wr_strb_ff);
    if (SYS_RST_I) begin
      command_source_select_ff <= SRC_RST;
    end else if (do_wr && wr_addr_ff == AW'(OFS_SRC) && m <= 32'(SRC_PLC)) begin
      command_source_select_ff <= m[2:0];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    logic [31:0] m;
    m = merge({18'h0, run_delay_ff}, wv, wr_strb_ff);
    if (SYS_RST_I) begin
      run_delay_ff <= DLY_RST;
    end else if (do_wr && wr_addr_ff == AW'(OFS_DLY) && m <= 32'(DLY_MAX)) begin
      run_delay_ff <= m[DLY_W-1:0];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    logic [31:0] m;
    m = merge({12'h0, SERIAL_FRAME_FORMAT_O, SERIAL_BIT_RATE_O,
               SERIAL_PROTOCOL_SELECT_O, SERIAL_STATION_NUMBER_O}, wv, wr_strb_ff);
    if (SYS_RST_I) begin
      SERIAL_STATION_NUMBER_O <= STN_RST;
      SERIAL_PROTOCOL_SELECT_O <= PROTO_RST;
      SERIAL_BIT_RATE_O <= RATE_RST;
      SERIAL_FRAME_FORMAT_O <= FRAME_RST;
    end else if (do_wr && wr_addr_ff == AW'(OFS_SER)) begin
      if (m[SER_STN_LSB +: 8] >= STN_MIN && m[SER_STN_LSB +: 8] <= STN_MAX) begin
        SERIAL_STATION_NUMBER_O <= m[SER_STN_LSB +: 8];
      end
      if (m[SER_RATE_LSB +: 4] <= RATE_MAX) begin
        SERIAL_BIT_RATE_O <= m[SER_RATE_LSB +: 4];
      end
      SERIAL_PROTOCOL_SELECT_O <= m[SER_PROTO_LSB +: 4];
      SERIAL_FRAME_FORMAT_O <= m[SER_FRAME_LSB +: 4];
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < N_TERM; i++) begin
      m = merge({26'h0, terminal_role_assign_ff[i]}, wv, wr_strb_ff);
      if (SYS_RST_I) begin
        terminal_role_assign_ff[i] <= ROLE_RST;
      end else if (do_wr && wr_addr_ff == AW'(OFS_ROLE + 4 * i) &&
                   m <= 32'(ROLE_MAX)) begin
        terminal_role_assign_ff[i] <= m[ROLE_W-1:0];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (ARADDR_I == AW'(OFS_SRC)) begin
      rd_val[2:0] = command_source_select_ff;
    end else if (ARADDR_I == AW'(OFS_DLY)) begin
      rd_val[DLY_W-1:0] = run_delay_ff;
    end else if (ARADDR_I == AW'(OFS_SER)) begin
      rd_val[SER_STN_LSB +: 8] = SERIAL_STATION_NUMBER_O;
      rd_val[SER_PROTO_LSB +: 4] = SERIAL_PROTOCOL_SELECT_O;
      rd_val[SER_RATE_LSB +: 4] = SERIAL_BIT_RATE_O;
      rd_val[SER_FRAME_LSB +: 4] = SERIAL_FRAME_FORMAT_O;
    end else if (ARADDR_I == AW'(OFS_STAT)) begin
      rd_val[STAT_FWD] = RUN_FWD_O;
      rd_val[STAT_REV] = RUN_REV_O;
      rd_val[STAT_BUSY] = DLY_BUSY_O;
      rd_val[STAT_SRC_LSB +: 3] = command_source_select_ff;
    end else begin
      rd_hit = 1'b0;
      for (int i = 0; i < N_TERM; i++) begin
        if (ARADDR_I == AW'(OFS_ROLE + 4 * i)) begin
          rd_hit = 1'b1;
          rd_val[ROLE_W-1:0] = terminal_role_assign_ff[i];
        end
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
      RDATA_O <= 32'h0000_0000;
      RRESP_O <= RESP_OKAY;
    end else if (ARREADY_O && ARVALID_I) begin
      ARREADY_O <= 1'b0;
      RVALID_O <= 1'b1;
      RDATA_O <= rd_val;
      RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID_O && RREADY_I) begin
      ARREADY_O <= 1'b1;
      RVALID_O <= 1'b0;
    end
  end

  // ==========================================================
  // keypad: keys act on their press edge, stop is a level and wins
  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      key_prev_ff <= 3'h0;
    end else begin
      key_prev_ff <= key_s;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I || command_source_select_ff != SRC_KEYPAD) begin
      kp_fwd_ff <= 1'b0;
      kp_rev_ff <= 1'b0;
    end else if (key_s[2]) begin
      kp_fwd_ff <= 1'b0;
      kp_rev_ff <= 1'b0;
    end else if (key_s[0] && !key_prev_ff[0]) begin
      kp_fwd_ff <= 1'b1;
      kp_rev_ff <= 1'b0;
    end else if (key_s[1] && !key_prev_ff[1]) begin
      kp_fwd_ff <= 1'b0;
      kp_rev_ff <= 1'b1;
    end
  end

  // ==========================================================
  // terminal decode and source selection
  assign fwd_in = role_hit(terminal_role_assign_ff, term_s, ROLE_FWD);
  assign rev_in = role_hit(terminal_role_assign_ff, term_s, ROLE_REV);

  // the delay restarts when the terminals fall back to stop or a non-terminal source is selected
  always_comb begin
    term_req = 1'b0;
    if (command_source_select_ff == SRC_FWD_REV) begin
      term_req = fwd_in ^ rev_in;
    end else if (command_source_select_ff == SRC_RUN_DIR) begin
      term_req = fwd_in;
    end
  end

  always_comb begin
    nxt_fwd = 1'b0;
    nxt_rev = 1'b0;
    case (command_source_select_ff)
      SRC_KEYPAD: begin
        nxt_fwd = kp_fwd_ff;
        nxt_rev = kp_rev_ff;
      end
      SRC_FWD_REV: begin
        nxt_fwd = dly_done && fwd_in && !rev_in;
        nxt_rev = dly_done && rev_in && !fwd_in;
      end
      SRC_RUN_DIR: begin
        nxt_fwd = dly_done && fwd_in && !rev_in;
        nxt_rev = dly_done && fwd_in && rev_in;
      end
      SRC_SERIAL: begin
        nxt_fwd = SER_RUN_I && !SER_REV_I;
        nxt_rev = SER_RUN_I && SER_REV_I;
      end
      SRC_FBUS: begin
        nxt_fwd = FBUS_RUN_I && !FBUS_REV_I;
        nxt_rev = FBUS_RUN_I && FBUS_REV_I;
      end
      SRC_PLC: begin
        nxt_fwd = PLC_RUN_I && !PLC_REV_I;
        nxt_rev = PLC_RUN_I && PLC_REV_I;
      end
      default: begin
        nxt_fwd = 1'b0;
        nxt_rev = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (SYS_RST_I) begin
      RUN_FWD_O <= 1'b0;
      RUN_REV_O <= 1'b0;
      DLY_BUSY_O <= 1'b0;
    end else begin
      RUN_FWD_O <= nxt_fwd;
      RUN_REV_O <= nxt_rev;
      DLY_BUSY_O <= term_req && !dly_done;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (SYS_RST_I);

  sequence s_kp_fwd;
    (command_source_select_ff == SRC_KEYPAD && key_s[0] && !key_prev_ff[0] && !key_s[2])
      ##1 (command_source_select_ff == SRC_KEYPAD);
  endsequence
  property p_kp_fwd;
    s_kp_fwd |=> RUN_FWD_O && !RUN_REV_O;
  endproperty
  a_kp_fwd: assert property (p_kp_fwd)
    else $error("keypad forward key did not start forward run");

  sequence s_kp_stop;
    (command_source_select_ff == SRC_KEYPAD && key_s[2])
      ##1 (command_source_select_ff == SRC_KEYPAD);
  endsequence
  property p_kp_stop;
    s_kp_stop |=> !RUN_FWD_O && !RUN_REV_O;
  endproperty
  a_kp_stop: assert property (p_kp_stop)
    else $error("keypad stop key did not stop the drive");

  property p_fr_rev;
    command_source_select_ff == SRC_FWD_REV && dly_done && rev_in && !fwd_in
      |=> RUN_REV_O && !RUN_FWD_O;
  endproperty
  a_fr_rev: assert property (p_fr_rev)
    else $error("reverse terminal did not run reverse");

  property p_fr_stop;
    command_source_select_ff == SRC_FWD_REV && (fwd_in == rev_in)
      |=> !RUN_FWD_O && !RUN_REV_O;
  endproperty
  a_fr_stop: assert property (p_fr_stop)
    else $error("equal terminals did not stop the drive");

  property p_dly_hold;
    term_req && !dly_done |=> !RUN_FWD_O && !RUN_REV_O && DLY_BUSY_O;
  endproperty
  a_dly_hold: assert property (p_dly_hold)
    else $error("terminal run began before the start delay");

  property p_rd_dir;
    command_source_select_ff == SRC_RUN_DIR && dly_done && fwd_in
      |=> (RUN_REV_O == $past(rev_in)) && (RUN_FWD_O == !$past(rev_in));
  endproperty
  a_rd_dir: assert property (p_rd_dir)
    else $error("direction input did not steer the run");

  property p_ser_run;
    command_source_select_ff == SRC_SERIAL && SER_RUN_I
      |=> (RUN_REV_O == $past(SER_REV_I)) && (RUN_FWD_O != RUN_REV_O);
  endproperty
  a_ser_run: assert property (p_ser_run)
    else $error("serial run request not followed");

  property p_ser_cfg;
    SERIAL_STATION_NUMBER_O >= STN_MIN && SERIAL_STATION_NUMBER_O <= STN_MAX &&
      SERIAL_BIT_RATE_O <= RATE_MAX;
  endproperty
  a_ser_cfg: assert property (p_ser_cfg)
    else $error("serial station or bit rate out of range");

  property p_frame_hold;
    !(do_wr && wr_addr_ff == AW'(OFS_SER)) |=> $stable(SERIAL_FRAME_FORMAT_O);
  endproperty
  a_frame_hold: assert property (p_frame_hold)
    else $error("frame format changed without a write");

  property p_src_range;
    command_source_select_ff <= SRC_PLC;
  endproperty
  a_src_range: assert property (p_src_range)
    else $error("source selector out of range");

  property p_ignore;
    command_source_select_ff == SRC_SERIAL && !SER_RUN_I |=> !RUN_FWD_O && !RUN_REV_O;
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("unselected source moved the drive");
endmodule
`default_nettype wire
